// ### rtl/sticky_flag_bank.sv
/*
 * Bank of sticky error flags, set by hardware pulses and cleared by
 * writing ones.
 * Assumes set and clear strobes are synchronous single-cycle pulses.
 */
`timescale 1ns/1ps

module sticky_flag_bank
(
    input  wire logic                             clk,       // Device clock
    input  wire logic                             rst,       // Async reset
    input  wire logic [uart_lsr_mcr_pkg::ERR_W-1:0] set_pulse, // Hardware events
    input  wire logic [uart_lsr_mcr_pkg::ERR_W-1:0] clr_pulse, // Write-one strobes
    output logic      [uart_lsr_mcr_pkg::ERR_W-1:0] flags      // Sticky flags
);

    typedef struct packed {
        logic [uart_lsr_mcr_pkg::ERR_W-1:0] flags;
    } bank_state_type;

    bank_state_type state_reg;
    bank_state_type state_next;

    // Set wins over a same-cycle clear
    always_comb
    begin
        state_next       = state_reg;
        state_next.flags = (state_reg.flags & ~clr_pulse) | set_pulse;
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.flags <= uart_lsr_mcr_pkg::ERR_FLAGS_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;

endmodule

// ### rtl/uart_line_status_modem_ctrl.sv
/*
 * Line-status flags, upper modem-control bits, loopback steering, DMA halt
 * and interrupt gating of one serial port, with an APB register slave.
 * Assumes the receiver, transmitter and DMA engine sit outside and share clk.
 */
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps

// How it works
// - The request-to-send pin follows control bit 5 unless loopback parks it high or auto flow control owns it.
// - In loopback the loop ring and loop carrier bits show as modem-status bits 6 and 7.
// - Loop select turns on loopback: serial out high, transmitter fed to receiver, pins cut.
// - In loopback terminal-ready shows in modem-status bit 4 and request-to-send in bit 5.
// - DMA is halted while overrun, parity, framing, break or the exit condition is set.
// - Status bit 0 records overrun, halts DMA, may interrupt, and clears on writing one.
// - Status bit 1 records a parity error, halts DMA, may interrupt, clears on writing one.
// - Status bit 2 records a framing error, halts DMA, may interrupt, clears on writing one.
// - Status bit 3 records a break, halts DMA, may interrupt, clears on writing one.
// - Status bit 4 is high while receive data is held and may raise the receive interrupt.
// - Status bit 5 is high while the transmit register is empty, resets high, may interrupt.
module uart_line_status_modem_ctrl
(
    input  wire logic                          clk,           // Device clock, 125 MHz
    input  wire logic                          rst,           // Async reset, high
    input  wire uart_lsr_mcr_pkg::apb_req_type apb_req,       // APB request
    output uart_lsr_mcr_pkg::apb_rsp_type      apb_rsp,       // APB response
    input  wire uart_lsr_mcr_pkg::rx_event_type rx_event,     // Receiver error pulses
    input  wire logic                          rx_data_held,  // Receive data present
    input  wire logic                          tx_data_empty, // Transmit data empty
    input  wire logic                          exit_cond,     // Exit condition level
    input  wire logic                          flow_ready,    // Auto flow: can accept
    input  wire uart_lsr_mcr_pkg::modem_in_type modem_in,     // Modem inputs, low active
    output uart_lsr_mcr_pkg::modem_out_type    modem_out,     // Modem outputs, low active
    input  wire logic                          tx_serial,     // Transmitter serial bit
    input  wire logic                          sin,           // Serial input pin
    output logic                               sout,          // Serial output pin
    output logic                               rx_serial,     // Bit fed to receiver
    output logic                               dma_halt,      // Halt DMA transfers
    output logic                               irq            // Interrupt, high level
);

    typedef struct packed {
        logic [uart_lsr_mcr_pkg::REG_W-1:0]  modem_control;
        logic [uart_lsr_mcr_pkg::REG_W-1:0]  int_mask;
        logic [uart_lsr_mcr_pkg::REG_W-1:0]  port_config;
        logic [uart_lsr_mcr_pkg::REG_W-1:0]  modem_status;
        logic                                rx_full;
        logic                                tx_empty;
        logic                                exit_seen;
        logic                                halt;
        logic                                irq;
        logic                                sout;
        logic                                rx_serial;
        logic                                rts_n;
        logic                                dtr_n;
        logic [uart_lsr_mcr_pkg::DATA_W-1:0] prdata;
    } ctrl_state_type;

    ctrl_state_type                    state_reg;
    ctrl_state_type                    state_next;
    logic [uart_lsr_mcr_pkg::ERR_W-1:0] err_flags;
    logic [uart_lsr_mcr_pkg::ERR_W-1:0] err_clear;
    logic [uart_lsr_mcr_pkg::ERR_W-1:0] err_set;
    logic                              wr_access;
    logic                              rd_setup;
    logic                              loop_on;
    logic                              auto_flow;
    logic [uart_lsr_mcr_pkg::REG_W-1:0] line_status;
    logic                              addr_hit;

    // Address decode shared by write strobe and error answer
    function automatic logic is_mapped(input logic [uart_lsr_mcr_pkg::ADDR_W-1:0] a);
        is_mapped = (a == uart_lsr_mcr_pkg::OFS_MODEM_CONTROL) ||
                    (a == uart_lsr_mcr_pkg::OFS_LINE_STATUS)   ||
                    (a == uart_lsr_mcr_pkg::OFS_MODEM_STATUS)  ||
                    (a == uart_lsr_mcr_pkg::OFS_INT_MASK)      ||
                    (a == uart_lsr_mcr_pkg::OFS_PORT_CONFIG);
    endfunction

    // Widen an 8-bit register to the bus, upper bits zero
    function automatic logic [uart_lsr_mcr_pkg::DATA_W-1:0] widen
        (input logic [uart_lsr_mcr_pkg::REG_W-1:0] v);
        widen = {{(uart_lsr_mcr_pkg::DATA_W-uart_lsr_mcr_pkg::REG_W){1'b0}}, v};
    endfunction

    // Bus phase strobes
    assign addr_hit  = is_mapped(apb_req.paddr);
    assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_hit;
    assign rd_setup  = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    // Mode controls
    assign loop_on   = state_reg.modem_control[uart_lsr_mcr_pkg::MC_LOOP_SELECT];
    assign auto_flow = state_reg.port_config[uart_lsr_mcr_pkg::CFG_AUTO_FLOW];

    // Error events into the sticky bank
    assign err_set = {rx_event.break_flag, rx_event.framing, rx_event.parity, rx_event.overrun};

    // Write-one clears of the four error bits only
    assign err_clear = (wr_access && apb_req.paddr == uart_lsr_mcr_pkg::OFS_LINE_STATUS)
                     ? apb_req.pwdata[uart_lsr_mcr_pkg::ERR_W-1:0]
                     : {uart_lsr_mcr_pkg::ERR_W{1'b0}};

    // Sticky overrun, parity, framing and break flags
    sticky_flag_bank u_err_flags
    (
        .clk       (clk),
        .rst       (rst),
        .set_pulse (err_set),
        .clr_pulse (err_clear),
        .flags     (err_flags)
    );

    // Line-status view, reserved bits held at zero
    always_comb
    begin
        line_status                               = '0;
        line_status[uart_lsr_mcr_pkg::LS_OVERRUN]  = err_flags[0];
        line_status[uart_lsr_mcr_pkg::LS_PARITY]   = err_flags[1];
        line_status[uart_lsr_mcr_pkg::LS_FRAMING]  = err_flags[2];
        line_status[uart_lsr_mcr_pkg::LS_BREAK]    = err_flags[3];
        line_status[uart_lsr_mcr_pkg::LS_RX_FULL]  = state_reg.rx_full;
        line_status[uart_lsr_mcr_pkg::LS_TX_EMPTY] = state_reg.tx_empty;
    end

    // Next state of the whole block
    always_comb
    begin
        state_next = state_reg;

        // Register writes at the access edge
        if (wr_access)
        begin
            case (apb_req.paddr)
                uart_lsr_mcr_pkg::OFS_MODEM_CONTROL:
                begin
                    state_next.modem_control = apb_req.pwdata[uart_lsr_mcr_pkg::REG_W-1:0]
                                             & uart_lsr_mcr_pkg::MODEM_CONTROL_MASK;
                end
                uart_lsr_mcr_pkg::OFS_INT_MASK:
                begin
                    state_next.int_mask = apb_req.pwdata[uart_lsr_mcr_pkg::REG_W-1:0]
                                        & uart_lsr_mcr_pkg::INT_MASK_MASK;
                end
                uart_lsr_mcr_pkg::OFS_PORT_CONFIG:
                begin
                    state_next.port_config = apb_req.pwdata[uart_lsr_mcr_pkg::REG_W-1:0]
                                           & uart_lsr_mcr_pkg::PORT_CONFIG_MASK;
                end
                default:
                begin
                    state_next.port_config = state_reg.port_config;
                end
            endcase
        end

        // Data-register condition flags follow the datapath
        state_next.rx_full   = rx_data_held;
        state_next.tx_empty  = tx_data_empty;
        state_next.exit_seen = exit_cond;

        // Modem status: loopback reflects control bits, else inverted pins
        if (loop_on)
        begin
            state_next.modem_status = '0;
            state_next.modem_status[uart_lsr_mcr_pkg::MS_CTS] =
                state_reg.modem_control[uart_lsr_mcr_pkg::MC_DTR];
            state_next.modem_status[uart_lsr_mcr_pkg::MS_DSR] =
                state_reg.modem_control[uart_lsr_mcr_pkg::MC_RTS];
            state_next.modem_status[uart_lsr_mcr_pkg::MS_RI]  =
                state_reg.modem_control[uart_lsr_mcr_pkg::MC_LOOP_RING];
            state_next.modem_status[uart_lsr_mcr_pkg::MS_CD]  =
                state_reg.modem_control[uart_lsr_mcr_pkg::MC_LOOP_CARR];
        end
        else
        begin
            state_next.modem_status = '0;
            state_next.modem_status[uart_lsr_mcr_pkg::MS_CTS] = !modem_in.cts_n;
            state_next.modem_status[uart_lsr_mcr_pkg::MS_DSR] = !modem_in.dsr_n;
            state_next.modem_status[uart_lsr_mcr_pkg::MS_RI]  = !modem_in.ri_n;
            state_next.modem_status[uart_lsr_mcr_pkg::MS_CD]  = !modem_in.dcd_n;
        end

        // Serial steering: loopback holds the line high and feeds back
        if (loop_on)
        begin
            state_next.sout      = 1'b1;
            state_next.rx_serial = tx_serial;
        end
        else
        begin
            state_next.sout      = tx_serial;
            state_next.rx_serial = sin;
        end

        // Modem outputs: loopback parks them, auto flow overrides control
        if (loop_on)
        begin
            state_next.rts_n = 1'b1;
            state_next.dtr_n = 1'b1;
        end
        else if (auto_flow)
        begin
            state_next.rts_n = !flow_ready;
            state_next.dtr_n = !flow_ready;
        end
        else
        begin
            state_next.rts_n = !state_reg.modem_control[uart_lsr_mcr_pkg::MC_RTS];
            state_next.dtr_n = !state_reg.modem_control[uart_lsr_mcr_pkg::MC_DTR];
        end

        // DMA halt on any error flag or the exit condition
        state_next.halt = (|err_flags) || state_reg.exit_seen;

        // Level interrupt from unmasked line-status bits
        state_next.irq = |(line_status & state_reg.int_mask);

        // Read data captured in the setup phase, stable through access
        if (rd_setup)
        begin
            case (apb_req.paddr)
                uart_lsr_mcr_pkg::OFS_MODEM_CONTROL:
                begin
                    state_next.prdata = widen(state_reg.modem_control);
                end
                uart_lsr_mcr_pkg::OFS_LINE_STATUS:
                begin
                    state_next.prdata = widen(line_status);
                end
                uart_lsr_mcr_pkg::OFS_MODEM_STATUS:
                begin
                    state_next.prdata = widen(state_reg.modem_status);
                end
                uart_lsr_mcr_pkg::OFS_INT_MASK:
                begin
                    state_next.prdata = widen(state_reg.int_mask);
                end
                uart_lsr_mcr_pkg::OFS_PORT_CONFIG:
                begin
                    state_next.prdata = widen(state_reg.port_config);
                end
                default:
                begin
                    state_next.prdata = '0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.modem_control <= uart_lsr_mcr_pkg::MODEM_CONTROL_RESET;
            state_reg.int_mask      <= uart_lsr_mcr_pkg::INT_MASK_RESET;
            state_reg.port_config   <= uart_lsr_mcr_pkg::PORT_CONFIG_RESET;
            state_reg.modem_status  <= '0;
            state_reg.rx_full       <= uart_lsr_mcr_pkg::RX_FULL_RESET;
            state_reg.tx_empty      <= uart_lsr_mcr_pkg::TX_EMPTY_RESET;
            state_reg.exit_seen     <= 1'b0;
            state_reg.halt          <= 1'b0;
            state_reg.irq           <= 1'b0;
            state_reg.sout          <= 1'b1;
            state_reg.rx_serial     <= 1'b1;
            state_reg.rts_n         <= 1'b1;
            state_reg.dtr_n         <= 1'b1;
            state_reg.prdata        <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Zero-wait APB answer, error on unmapped address
    always_comb
    begin
        apb_rsp.prdata  = state_reg.prdata;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;
    end

    // Registered outputs
    assign modem_out.rts_n = state_reg.rts_n;
    assign modem_out.dtr_n = state_reg.dtr_n;
    assign sout            = state_reg.sout;
    assign rx_serial       = state_reg.rx_serial;
    assign dma_halt        = state_reg.halt;
    assign irq             = state_reg.irq;

endmodule

// ### rtl/uart_lsr_mcr_pkg.sv
/*
 * Shared constants and carrier types for the line-status and modem-control
 * block of one serial port.
 * Assumes an APB slave with 32-bit data and byte addresses on paddr.
 */
package uart_lsr_mcr_pkg;

    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int ERR_W  = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MODEM_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LINE_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MODEM_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK      = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PORT_CONFIG   = 8'h10;

    // Modem-control fields
    localparam int MC_LOOP_SELECT = 2;
    localparam int MC_DTR         = 4;
    localparam int MC_RTS         = 5;
    localparam int MC_LOOP_RING   = 6;
    localparam int MC_LOOP_CARR   = 7;

    // Line-status fields
    localparam int LS_OVERRUN   = 0;
    localparam int LS_PARITY    = 1;
    localparam int LS_FRAMING   = 2;
    localparam int LS_BREAK     = 3;
    localparam int LS_RX_FULL   = 4;
    localparam int LS_TX_EMPTY  = 5;

    // Modem-status fields
    localparam int MS_CTS = 4;
    localparam int MS_DSR = 5;
    localparam int MS_RI  = 6;
    localparam int MS_CD  = 7;

    // Port-config fields
    localparam int CFG_AUTO_FLOW = 0;

    // Values after reset
    localparam logic [REG_W-1:0] MODEM_CONTROL_RESET = 8'h00;
    localparam logic [REG_W-1:0] INT_MASK_RESET      = 8'h00;
    localparam logic [REG_W-1:0] PORT_CONFIG_RESET   = 8'h00;
    localparam logic             TX_EMPTY_RESET      = 1'h1;
    localparam logic             RX_FULL_RESET       = 1'h0;
    localparam logic [ERR_W-1:0] ERR_FLAGS_RESET     = 4'h0;

    // Writable bits of each register
    localparam logic [REG_W-1:0] MODEM_CONTROL_MASK = 8'hF4;
    localparam logic [REG_W-1:0] INT_MASK_MASK      = 8'h3F;
    localparam logic [REG_W-1:0] PORT_CONFIG_MASK   = 8'h01;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic break_flag;
        logic framing;
        logic parity;
        logic overrun;
    } rx_event_type;

    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic dcd_n;
        logic ri_n;
    } modem_in_type;

    typedef struct packed {
        logic rts_n;
        logic dtr_n;
    } modem_out_type;

endpackage

// ### test/uart_dma_partner.sv
/*
 * Behavioural DMA engine that moves one word a cycle unless halted.
 * Assumes the device clock and its active-high asynchronous reset.
 */
`timescale 1ns/1ps

module uart_dma_partner
(
    input  wire logic        clk,      // Device clock
    input  wire logic        rst,      // Async reset
    input  wire logic        dma_halt, // Halt from the port
    output logic      [15:0] moves     // Words moved so far
);
    // Count transfers, pausing while the port holds the halt
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            moves <= 16'h0;
        else if (!dma_halt)
            moves <= moves + 16'h1;
    end
endmodule

// ### test/uart_line_status_modem_ctrl_bench.sv
/*
 * Self-checking bench: APB master, register model and DMA partner.
 * Assumes the design package and the bound checker are compiled first.
 */
`timescale 1ns/1ps

module uart_line_status_modem_ctrl_bench;
    logic                           clk, rst, rx_data_held, tx_data_empty, exit_cond;
    logic                           flow_ready, tx_serial, sin, sout, rx_serial, dma_halt, irq;
    uart_lsr_mcr_pkg::apb_req_type  req;
    uart_lsr_mcr_pkg::apb_rsp_type  rsp;
    uart_lsr_mcr_pkg::rx_event_type rx_event;
    uart_lsr_mcr_pkg::modem_in_type modem_in;
    uart_lsr_mcr_pkg::modem_out_type modem_out;
    logic [15:0]                    moves;
    logic [31:0]                    q, d;
    logic                           e;
    int                             n_errors, compares, i, mc_m, msk_m, cfg_m, err_m;

    always #4 clk = ~clk;

    uart_line_status_modem_ctrl u_dut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .rx_event(rx_event), .rx_data_held(rx_data_held), .tx_data_empty(tx_data_empty),
        .exit_cond(exit_cond), .flow_ready(flow_ready), .modem_in(modem_in),
        .modem_out(modem_out), .tx_serial(tx_serial), .sin(sin), .sout(sout),
        .rx_serial(rx_serial), .dma_halt(dma_halt), .irq(irq));
    uart_dma_partner u_dma (.clk(clk), .rst(rst), .dma_halt(dma_halt), .moves(moves));

    task give_verdict();
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Model of the status byte
    function automatic int ls_m();
        return (tx_data_empty << 5) | (rx_data_held << 4) | err_m;
    endfunction

    function automatic logic [31:0] rd_m(input logic [7:0] a);
        case (a)
            8'h00: return mc_m;
            8'h04: return ls_m();
            8'h08: return mc_m[2] ? (mc_m & 8'hF0) : {~modem_in.dcd_n, ~modem_in.ri_n,
                ~modem_in.dsr_n, ~modem_in.cts_n, 4'h0};
            8'h0C: return msk_m;
            8'h10: return cfg_m;
            default: return 0;
        endcase
    endfunction

    // One APB transfer, held until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 16);
        if (rsp.pready !== 1'b1)
        begin
            n_errors++;
            give_verdict();
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
        case (a)
            8'h00: mc_m = wd & uart_lsr_mcr_pkg::MODEM_CONTROL_MASK;
            8'h04: err_m = err_m & ~wd[3:0];
            8'h0C: msk_m = wd & uart_lsr_mcr_pkg::INT_MASK_MASK;
            8'h10: cfg_m = wd & uart_lsr_mcr_pkg::PORT_CONFIG_MASK;
            default: ;
        endcase
    endtask

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        chk("prdata", rd_m(a), q);
        chk("pslverr", a > 8'h10, e);
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task pins();
        #1;
        chk("rts_n", mc_m[2] ? 1 : cfg_m[0] ? !flow_ready : !mc_m[5], modem_out.rts_n);
        chk("dtr_n", mc_m[2] ? 1 : cfg_m[0] ? !flow_ready : !mc_m[4], modem_out.dtr_n);
        chk("sout", mc_m[2] ? 1 : tx_serial, sout);
        chk("rx_serial", mc_m[2] ? tx_serial : sin, rx_serial);
    endtask

    task flags();
        chk("dma_halt", err_m != 0 || exit_cond, dma_halt);
        chk("irq", (ls_m() & msk_m) != 0, irq);
    endtask

    initial
    begin
        {clk, rx_data_held, exit_cond, flow_ready, req, rx_event} = '0;
        {rst, tx_data_empty, tx_serial, sin, modem_in} = '1;
        {n_errors, compares, mc_m, msk_m, cfg_m, err_m} = '0;
        void'($urandom(32'h9FA8));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i <= 24; i += 4) rd(i[7:0]);
        // Random control values, loopback on and off
        for (i = 0; i < 6; i++)
        begin
            @(posedge clk);
            modem_in <= 4'($urandom);
            tx_serial <= 1'($urandom);
            sin <= 1'($urandom);
            d = $urandom;
            d[2] = i[0];
            wr(8'h00, d);
            rd(8'h00);
            rd(8'h08);
            pins();
        end
        // Auto flow takes the pins from modem control
        wr(8'h00, 32'h30);
        wr(8'h10, 32'h1);
        for (i = 0; i < 2; i++)
        begin
            @(posedge clk);
            flow_ready <= i[0];
            settle(3);
            pins();
        end
        wr(8'h10, 32'h0);
        // Each error alone, then all at once; mask dropped half way
        wr(8'h0C, 32'h0F);
        for (i = 0; i < 5; i++)
        begin
            @(posedge clk);
            rx_event <= (i < 4) ? 4'(1 << i) : 4'hF;
            @(posedge clk);
            rx_event <= 4'h0;
            err_m = (i < 4) ? (1 << i) : 15;
            settle(3);
            flags();
            d = moves;
            settle(4);
            chk("moves", d, moves);
            wr(8'h04, 32'h0);
            rd(8'h04);
            wr(8'h04, err_m);
            settle(3);
            flags();
            if (i == 2) wr(8'h0C, 32'h0);
        end
        @(posedge clk);
        exit_cond <= 1'b1;
        settle(3);
        flags();
        @(posedge clk);
        exit_cond <= 1'b0;
        settle(3);
        flags();
        // Receive full and transmit empty interrupts
        wr(8'h0C, 32'h30);
        @(posedge clk);
        rx_data_held <= 1'b1;
        tx_data_empty <= 1'b0;
        settle(3);
        flags();
        rd(8'h04);
        @(posedge clk);
        rx_data_held <= 1'b0;
        settle(3);
        flags();
        @(posedge clk);
        tx_data_empty <= 1'b1;
        settle(3);
        flags();
        give_verdict();
    end
endmodule

// ### test/uart_lsr_mcr_assertions.sv
/*
 * Port checks of the line-status and modem-control block.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps

module uart_lsr_mcr_assertions
(
    input wire logic                            clk,           // Clock
    input wire logic                            rst,           // Reset
    input wire uart_lsr_mcr_pkg::apb_req_type   apb_req,       // Bus request
    input wire uart_lsr_mcr_pkg::apb_rsp_type   apb_rsp,       // Bus answer
    input wire uart_lsr_mcr_pkg::rx_event_type  rx_event,      // Error pulses
    input wire logic                            rx_data_held,  // Rx full
    input wire logic                            tx_data_empty, // Tx empty
    input wire logic                            exit_cond,     // Exit level
    input wire logic                            flow_ready,    // Flow ready
    input wire uart_lsr_mcr_pkg::modem_out_type modem_out,     // Modem pins
    input wire logic                            tx_serial,     // Tx bit
    input wire logic                            sin,           // Serial in
    input wire logic                            sout,          // Serial out
    input wire logic                            rx_serial,     // Rx bit
    input wire logic                            dma_halt,      // DMA halt
    input wire logic                            irq            // Interrupt
);
    logic wr_acc;  // Write in access phase
    logic [5:0] sh; // Loop, dtr, rts, auto, rx mask, tx mask

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;

    // Shadow of the control bits, taken at the access edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sh <= 6'h0;
        else if (wr_acc && apb_req.paddr == 8'h00)
            sh[2:0] <= {apb_req.pwdata[2], apb_req.pwdata[4], apb_req.pwdata[5]};
        else if (wr_acc && apb_req.paddr == 8'h10)
            sh[3] <= apb_req.pwdata[0];
        else if (wr_acc && apb_req.paddr == 8'h0C)
            sh[5:4] <= apb_req.pwdata[5:4];
    end

    sequence s_clear_all;
        wr_acc && apb_req.paddr == 8'h04 && apb_req.pwdata[3:0] == 4'hF
            && rx_event == 4'h0 && !exit_cond;
    endsequence
    sequence s_rx_unmasked;
        rx_data_held ##1 sh[4];
    endsequence
    sequence s_tx_unmasked;
        tx_data_empty ##1 sh[5];
    endsequence

    chk_halt_on_error: assert property (rx_event != 4'h0 |-> ##2 dma_halt)
        else $error("error event did not halt DMA");
    chk_halt_on_exit: assert property (exit_cond |-> ##2 dma_halt)
        else $error("exit condition did not halt DMA");
    chk_clear_releases: assert property (s_clear_all |-> ##2 !dma_halt)
        else $error("halt stayed after clearing all flags");
    chk_loop_parks: assert property (sh[2] |=> sout && modem_out.rts_n && modem_out.dtr_n)
        else $error("loopback did not park the pins");
    chk_loop_feed: assert property (sh[2] |=> rx_serial == $past(tx_serial))
        else $error("loopback did not feed transmitter to receiver");
    chk_normal_feed: assert property (!sh[2]
        |=> rx_serial == $past(sin) && sout == $past(tx_serial))
        else $error("serial path wrong outside loopback");
    chk_auto_flow: assert property (sh[3] && !sh[2]
        |=> modem_out.rts_n == !$past(flow_ready) && modem_out.dtr_n == !$past(flow_ready))
        else $error("auto flow did not own the pins");
    chk_manual_pins: assert property (!sh[3] && !sh[2]
        |=> modem_out.rts_n == !$past(sh[0]) && modem_out.dtr_n == !$past(sh[1]))
        else $error("pins do not follow modem control");
    chk_rx_irq: assert property (s_rx_unmasked |=> irq)
        else $error("receive interrupt missing");
    chk_tx_irq: assert property (s_tx_unmasked |=> irq)
        else $error("transmit interrupt missing");
    chk_reserved_zero: assert property (apb_req.psel && apb_req.penable
        && !apb_req.pwrite && apb_req.paddr == 8'h04 |-> apb_rsp.prdata[31:6] == 26'h0)
        else $error("reserved status bits not zero");
endmodule

bind uart_line_status_modem_ctrl uart_lsr_mcr_assertions u_chk
(
    .clk, .rst, .apb_req, .apb_rsp, .rx_event, .rx_data_held, .tx_data_empty, .exit_cond,
    .flow_ready, .modem_out, .tx_serial, .sin, .sout, .rx_serial, .dma_halt, .irq
);
